// ==== design/src_core.sv ====
/*
  Serial clock/calendar register core: I2C-style slave byte engine,
  BCD time counters, reset debounce and battery switch-over.
  Assumes SCL/SDA and reset inputs are asynchronous pins; an external
  pad resolves sda from its output enable (drives low only).
*/
`timescale 1ns/1ps
module src_core
  import src_pkg::*;
#(
  parameter int SLAVE_ADDR = 7'h68, // arbitrary
  parameter int HUND_DIV   = SRC_HUND_CYCLES,
  parameter int DEB_CYCLES = SRC_DEBOUNCE_CYCLES
)(
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_oe_out,
  input  wire logic power_fail_sense_in,
  input  wire logic reset_request_in_a,
  input  wire logic reset_request_in_b,
  output logic      power_fail_flag_out,
  output logic      on_battery_out,
  output logic      reset_out,
  output logic      alarm_match_out
);
  import src_pkg::*;
  // Refuse settings that the 7-bit address or 16-bit debounce counters cannot hold
  if (SLAVE_ADDR > 127 || HUND_DIV < 2 || DEB_CYCLES < 1 || DEB_CYCLES > 65535)
  begin : g_bad_param
    $error("src_core: bad parameter");
  end

  // Two-flop synchronisers for all pins but reset_in
  logic [4:0] s1_reg, s2_reg, s3_reg;
  always_ff @(posedge clk_sys_in)
  begin
    s1_reg <= {reset_request_in_b, reset_request_in_a, power_fail_sense_in, sda_in, scl_in};
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end
  wire scl = s2_reg[0], sda = s2_reg[1], pfail = s2_reg[2];
  wire scl_rise = s2_reg[0] & ~s3_reg[0];
  wire scl_fall = ~s2_reg[0] & s3_reg[0];
  wire start_c  = scl & s3_reg[0] & ~sda & s3_reg[1];
  wire stop_c   = scl & s3_reg[0] & sda & ~s3_reg[1];

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // Month length in BCD; leap every fourth year, good until 2100
  function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
    logic [4:0] bin;
    bin = 5'(y[7:4]) * 5'd10 + 5'(y[3:0]);
    case (m)
      8'h02:   month_len = (bin[1:0] == 2'b00) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction : month_len

  // Time counter state
  logic [7:0] hund_reg, sec_reg, min_reg, hour_reg, day_reg, date_reg, mon_reg, year_reg;
  logic [1:0] cent_reg;
  logic [7:0] hund_next, sec_next, min_next, hour_next, day_next, date_next, mon_next;
  logic [7:0] year_next;
  logic [1:0] cent_next;
  logic [31:0] div_reg, div_next;
  logic        tick;
  logic        tw_en;
  logic [5:0]  tw_addr;
  logic [7:0]  tw_data;

  // Hundredths enable from a divider standing in for the 32.768 kHz crystal chain
  assign tick = (div_reg == 32'(HUND_DIV - 1));

  // Calendar advance; counters keep running on battery
  always_comb
  begin
    div_next  = tick ? 32'h0000_0000 : div_reg + 32'h0000_0001;
    hund_next = hund_reg; sec_next = sec_reg; min_next = min_reg; hour_next = hour_reg;
    day_next  = day_reg; date_next = date_reg; mon_next = mon_reg; year_next = year_reg;
    cent_next = cent_reg;
    if (tick)
    begin
      hund_next = bcd_inc(hund_reg);
      if (hund_reg == 8'h99)
      begin
        hund_next = 8'h00;
        sec_next  = bcd_inc(sec_reg);
        if (sec_reg == 8'h59)
        begin
          sec_next = 8'h00;
          min_next = bcd_inc(min_reg);
          if (min_reg == 8'h59)
          begin
            min_next  = 8'h00;
            hour_next = bcd_inc(hour_reg);
            if (hour_reg == 8'h23)
            begin
              hour_next = 8'h00;
              day_next  = (day_reg == 8'h07) ? 8'h01 : bcd_inc(day_reg);
              date_next = bcd_inc(date_reg);
              if (date_reg == month_len(mon_reg, year_reg))
              begin
                date_next = 8'h01;
                mon_next  = bcd_inc(mon_reg);
                if (mon_reg == 8'h12)
                begin
                  mon_next  = 8'h01;
                  year_next = bcd_inc(year_reg);
                  if (year_reg == 8'h99)
                  begin
                    year_next = 8'h00;
                    cent_next = cent_reg + 2'd1;
                  end
                end
              end
            end
          end
        end
      end
    end
    // Host writes win over the tick so a set time is never lost
    if (tw_en)
    begin
      case (tw_addr)
        SRC_A_HUND:  hund_next = tw_data;
        SRC_A_SEC:   sec_next  = tw_data;
        SRC_A_MIN:   min_next  = tw_data;
        SRC_A_HOUR:
        begin
          hour_next = {2'b00, tw_data[5:0]};
          cent_next = tw_data[7:SRC_CENT_LSB];
        end
        SRC_A_DAY:   day_next  = tw_data;
        SRC_A_DATE:  date_next = tw_data;
        SRC_A_MONTH: mon_next  = tw_data;
        SRC_A_YEAR:  year_next = tw_data;
        default:     ;
      endcase
    end
  end

  // Clock registers; reset loads the calendar defaults and clears the divider
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      div_reg <= 32'h0000_0000;
      hund_reg <= 8'h00; sec_reg <= 8'h00; min_reg <= 8'h00; hour_reg <= 8'h00;
      day_reg <= SRC_RST_DAY; date_reg <= SRC_RST_DATE; mon_reg <= SRC_RST_MONTH;
      year_reg <= 8'h00; cent_reg <= 2'b00;
    end
    else
    begin
      div_reg <= div_next;
      hund_reg <= hund_next; sec_reg <= sec_next; min_reg <= min_next;
      hour_reg <= hour_next; day_reg <= day_next; date_reg <= date_next;
      mon_reg <= mon_next; year_reg <= year_next; cent_reg <= cent_next;
    end
  end

  // Serial byte engine
  src_mem_if mif();
  src_mem u_mem (.clk_sys_in(clk_sys_in), .port(mif.mem));

  src_bus_state_t st_reg, st_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] bit_reg, bit_next;
  logic [5:0] ptr_reg, ptr_next;
  logic       rd_reg, rd_next, first_reg, first_next, nak_reg, nak_next;
  logic       oe_reg, oe_next;
  logic [7:0] rbyte;

  // Read mux: clock bytes come from the counters, the rest from memory
  always_comb
  begin
    case (ptr_reg)
      SRC_A_HUND:  rbyte = hund_reg;
      SRC_A_SEC:   rbyte = sec_reg;
      SRC_A_MIN:   rbyte = min_reg;
      SRC_A_HOUR:  rbyte = {cent_reg, hour_reg[5:0]};
      SRC_A_DAY:   rbyte = day_reg;
      SRC_A_DATE:  rbyte = date_reg;
      SRC_A_MONTH: rbyte = mon_reg;
      SRC_A_YEAR:  rbyte = year_reg;
      default:     rbyte = mif.rdata;
    endcase
  end

  always_comb
  begin
    st_next = st_reg; sh_next = sh_reg; bit_next = bit_reg; ptr_next = ptr_reg;
    rd_next = rd_reg; first_next = first_reg; nak_next = nak_reg; oe_next = oe_reg;
    tw_en = 1'b0; tw_addr = ptr_reg; tw_data = sh_reg;
    mif.we = 1'b0; mif.addr = ptr_reg; mif.wdata = sh_reg;
    case (st_reg)
      SRC_IDLE: oe_next = 1'b0;
      SRC_ADDR, SRC_WR:
        if (scl_rise)
        begin
          sh_next  = {sh_reg[6:0], sda};
          bit_next = bit_reg + 4'd1;
        end
        else if (scl_fall && bit_reg == 4'd8)
        begin
          bit_next = 4'd0;
          if (st_reg == SRC_ADDR)
          begin
            if (sh_reg[7:1] == 7'(SLAVE_ADDR))
            begin
              oe_next = 1'b1; rd_next = sh_reg[0]; first_next = 1'b1;
              st_next = SRC_ACK;
            end
            else st_next = SRC_IDLE;
          end
          else
          begin
            oe_next = 1'b1; st_next = SRC_ACK;
            if (first_reg) ptr_next = sh_reg[5:0];
            else
            begin
              tw_en = 1'b1; mif.we = 1'b1;
              ptr_next = ptr_reg + 6'd1;
            end
            first_next = 1'b0;
          end
        end
      SRC_ACK:
        if (scl_fall)
        begin
          if (rd_reg)
          begin
            sh_next = rbyte; oe_next = ~rbyte[7]; st_next = SRC_RD; bit_next = 4'd1;
          end
          else
          begin
            oe_next = 1'b0; st_next = SRC_WR; bit_next = 4'd0;
          end
        end
      SRC_RD:
        if (scl_rise && bit_reg == 4'd9)
        begin
          nak_next = sda;
          if (sda) st_next = SRC_IDLE;
        end
        else if (scl_fall)
        begin
          if (bit_reg == 4'd8)
          begin
            oe_next = 1'b0; bit_next = 4'd9;
            ptr_next = ptr_reg + 6'd1;
          end
          else if (bit_reg == 4'd9)
          begin
            sh_next = rbyte; oe_next = ~rbyte[7]; bit_next = 4'd1;
          end
          else
          begin
            oe_next = ~sh_reg[6]; sh_next = {sh_reg[6:0], 1'b0};
            bit_next = bit_reg + 4'd1;
          end
        end
      default: st_next = SRC_IDLE;
    endcase
    if (start_c)
    begin
      st_next = SRC_ADDR; bit_next = 4'd0; oe_next = 1'b0;
    end
    else if (stop_c) st_next = SRC_IDLE;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      st_reg <= SRC_IDLE; sh_reg <= 8'h00; bit_reg <= 4'd0; ptr_reg <= 6'd0;
      rd_reg <= 1'b0; first_reg <= 1'b0; nak_reg <= 1'b0; oe_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next; sh_reg <= sh_next; bit_reg <= bit_next; ptr_reg <= ptr_next;
      rd_reg <= rd_next; first_reg <= first_next; nak_reg <= nak_next; oe_reg <= oe_next;
    end
  end
  assign sda_oe_out = oe_reg;

  // Reset debounce, power-on stretch, battery switch and alarm
  logic [15:0] deb_a_reg, deb_b_reg, por_reg;
  logic        rst_reg, bat_reg, pf_reg, alm_reg;
  logic [15:0] deb_a_next, deb_b_next, por_next;
  logic        rst_next, alm_next;
  always_comb
  begin
    deb_a_next = s2_reg[3] ? 16'h0000 : (deb_a_reg == 16'(DEB_CYCLES) ? deb_a_reg
                                                                        : deb_a_reg + 16'h0001);
    deb_b_next = s2_reg[4] ? 16'h0000 : (deb_b_reg == 16'(DEB_CYCLES) ? deb_b_reg
                                                                        : deb_b_reg + 16'h0001);
    por_next   = (por_reg == 16'(SRC_POR_CYCLES)) ? por_reg : por_reg + 16'h0001;
    rst_next   = (por_reg != 16'(SRC_POR_CYCLES)) || (deb_a_reg == 16'(DEB_CYCLES))
                 || (deb_b_reg == 16'(DEB_CYCLES));
    alm_next   = (sec_reg == mif.rdata) && (st_reg == SRC_IDLE);
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      deb_a_reg <= 16'h0000; deb_b_reg <= 16'h0000; por_reg <= 16'h0000;
      rst_reg <= 1'b1; bat_reg <= 1'b0; pf_reg <= 1'b0; alm_reg <= 1'b0;
    end
    else
    begin
      deb_a_reg <= deb_a_next; deb_b_reg <= deb_b_next; por_reg <= por_next;
      rst_reg <= rst_next; bat_reg <= pfail; pf_reg <= pfail; alm_reg <= alm_next;
    end
  end
  assign reset_out           = rst_reg;
  assign on_battery_out      = bat_reg;
  assign power_fail_flag_out = pf_reg;
  assign alarm_match_out     = alm_reg;
endmodule : src_core

// ==== design/src_mem.sv ====
/*
  Byte-wide 64-location memory for user and control bytes with a
  registered read port. Assumes synchronous use on clk_sys_in.
*/
`timescale 1ns/1ps
module src_mem
  import src_pkg::*;
(
  input  wire logic clk_sys_in,
  src_mem_if.mem    port
);
  logic [7:0] store [SRC_DEPTH];
  logic [7:0] rd_reg;

  // Write and registered read; contents persist across reset like battery RAM
  always_ff @(posedge clk_sys_in)
  begin
    if (port.we)
      store[port.addr] <= port.wdata;
    rd_reg <= store[port.addr];
  end
  assign port.rdata = rd_reg;
endmodule : src_mem

// ==== design/src_mem_if.sv ====
/*
  Interface carrying the port to the 64-byte memory.
  Assumes both ends run on clk_sys_in.
*/
`timescale 1ns/1ps
interface src_mem_if;
  logic       we;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface : src_mem_if

// ==== design/src_pkg.sv ====
/*
  Package for the serial clock/calendar register core: address map,
  counter limits, timing counts and state encodings.
  Assumes a single 125 MHz system clock.
*/
package src_pkg;
  localparam int SRC_DEPTH       = 64;
  localparam int SRC_AW          = 6;
  localparam int SRC_CLOCK_BYTES = 8;
  localparam int SRC_CTRL_BYTES  = 12;
  localparam int SRC_USER_BYTES  = 44;
  // Clock/calendar, control and user byte offsets
  localparam logic [5:0] SRC_A_HUND   = 6'h00;
  localparam logic [5:0] SRC_A_SEC    = 6'h01;
  localparam logic [5:0] SRC_A_MIN    = 6'h02;
  localparam logic [5:0] SRC_A_HOUR   = 6'h03;
  localparam logic [5:0] SRC_A_DAY    = 6'h04;
  localparam logic [5:0] SRC_A_DATE   = 6'h05;
  localparam logic [5:0] SRC_A_MONTH  = 6'h06;
  localparam logic [5:0] SRC_A_YEAR   = 6'h07;
  localparam logic [5:0] SRC_A_CTRL0  = 6'h08;
  localparam logic [5:0] SRC_A_USER0  = 6'h14;
  // Century lives in bits 7:6 of the hour byte
  localparam int SRC_CENT_LSB = 6;
  // Timebase
  localparam int SRC_CLK_HZ      = 125_000_000;
  localparam int SRC_XTAL_HZ     = 32_768;
  localparam int SRC_HUND_HZ     = 100;
  localparam int SRC_HUND_CYCLES = SRC_CLK_HZ / SRC_HUND_HZ;
  // Reset input debounce (sys cycles) and reset pulse width
  localparam int SRC_DEBOUNCE_NS     = 20_000;
  localparam int SRC_DEBOUNCE_CYCLES = SRC_DEBOUNCE_NS / 8;
  localparam int SRC_POR_CYCLES      = 16;
  // Reset values
  localparam logic [7:0] SRC_RST_DATE  = 8'h01;
  localparam logic [7:0] SRC_RST_MONTH = 8'h01;
  localparam logic [7:0] SRC_RST_DAY   = 8'h01;
  // Bus engine states, one-hot
  typedef enum logic [4:0] {
    SRC_IDLE = 5'b0_0001,
    SRC_ADDR = 5'b0_0010,
    SRC_WR   = 5'b0_0100,
    SRC_RD   = 5'b0_1000,
    SRC_ACK  = 5'b1_0000
  } src_bus_state_t;
endpackage : src_pkg

// ==== tb/serial_rtc_register_core_tb_top.sv ====
/*
  Self-checking bench for src_core with a byte-array reference model.
  Assumes the host model in src_i2c_host and a pulled-up data line.
*/
`timescale 1ns/1ps
module serial_rtc_register_core_tb_top;
  import src_pkg::*;
  localparam int HUND = 1000;
  logic       clk_sys_in, reset_in, pf_in, req_a, req_b;
  logic       scl, sda_low, sda_oe, pf_flag, on_batt, rst_out, alarm;
  wire        sda = !(sda_low | sda_oe);
  int         bad_count, cmp_count, cyc;
  logic [7:0] mem_m [64];
  logic [7:0] rq [$];
  logic [7:0] dq [$];
  int         cy [5] = '{24, 23, 24, 23, 99};
  int         cm [5] = '{2, 2, 2, 4, 12};
  int         cd [5] = '{28, 28, 29, 30, 31};
  src_core #(.HUND_DIV(HUND), .DEB_CYCLES(2)) uut (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .scl_in(scl), .sda_in(sda), .sda_oe_out(sda_oe),
    .power_fail_sense_in(pf_in), .reset_request_in_a(req_a), .reset_request_in_b(req_b),
    .power_fail_flag_out(pf_flag), .on_battery_out(on_batt), .reset_out(rst_out),
    .alarm_match_out(alarm));
  src_i2c_host host (.clk_sys_in(clk_sys_in), .sda_line_in(sda), .scl_out(scl),
    .sda_low_out(sda_low));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // Hang guard, well above the roughly 50k cycles the run needs
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 70000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cyc_n
  // Address byte then pointer; the pointer byte comes before any data
  task automatic set_ptr(input int ptr);
    logic [7:0] r;
    logic       a;
    host.start();
    host.xfer({7'h68, 1'b0}, 1'b1, r, a);
    chk({7'h0, a}, 8'h00, "address ack");
    host.xfer(8'(ptr), 1'b1, r, a);
  endtask : set_ptr
  task automatic wr(input int ptr);
    logic [7:0] r;
    logic       a;
    set_ptr(ptr);
    foreach (dq[i])
    begin
      host.xfer(dq[i], 1'b1, r, a);
      chk({7'h0, a}, 8'h00, "data ack");
      mem_m[(ptr + i) % 64] = dq[i];
    end
    host.stop();
  endtask : wr
  task automatic rd(input int ptr, input int n);
    logic [7:0] r;
    logic       a;
    set_ptr(ptr);
    host.stop();
    host.start();
    host.xfer({7'h68, 1'b1}, 1'b1, r, a);
    rq = {};
    for (int i = 0; i < n; i++)
    begin
      host.xfer(8'h00 | 8'hff, i == n - 1, r, a);
      rq.push_back(r);
    end
    host.stop();
  endtask : rd
  function automatic int days_in(input int y, input int m);
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
    return 31;
  endfunction : days_in
  function automatic logic [7:0] i2b(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : i2b
  initial
  begin
    logic [7:0] r;
    logic       a;
    int         d, m, y, c;
    {reset_in, pf_in, req_a, req_b} = 4'b1011;
    bad_count = 0;
    cmp_count = 0;
    void'($urandom(64691));
    cyc_n(20);
    reset_in = 1'b0;
    cyc_n(2);
    chk({7'h0, rst_out}, 8'h01, "reset stretch");
    for (int i = 0; i < 40 && rst_out !== 1'b0; i++) cyc_n(1);
    chk({7'h0, rst_out}, 8'h00, "reset end");
    // Wrong device address is ignored
    host.start();
    host.xfer({7'h69, 1'b0}, 1'b1, r, a);
    chk({7'h0, a}, 8'h01, "foreign address nak");
    host.stop();
    // Control and user areas, random data, one burst each way
    dq = {};
    repeat (SRC_CTRL_BYTES + SRC_USER_BYTES) dq.push_back(8'($urandom));
    wr(SRC_A_CTRL0);
    rd(SRC_A_CTRL0, SRC_CTRL_BYTES + SRC_USER_BYTES);
    foreach (rq[i]) chk(rq[i], mem_m[SRC_A_CTRL0 + i], "stored byte");
    // Calendar roll-overs from 23:59:59.99 across month ends, plus Feb 28 of a leap year
    for (int k = 0; k < 5; k++)
    begin
      c = $urandom % 3;
      dq = '{8'h00, 8'h59, 8'h59, 8'(8'h23 | (c << SRC_CENT_LSB)), 8'h07, i2b(cd[k]),
             i2b(cm[k]), i2b(cy[k])};
      wr(0);
      dq = '{8'h99};
      wr(0);
      cyc_n(2 * HUND);
      rd(1, 7);
      d = cd[k] + 1;
      m = cm[k];
      y = cy[k];
      if (d > days_in(y, m))
      begin
        d = 1;
        m++;
        if (m > 12)
        begin
          m = 1;
          y++;
          if (y > 99)
          begin
            y = 0;
            c++;
          end
        end
      end
      chk(rq[0], 8'h00, "seconds");
      chk(rq[1], 8'h00, "minutes");
      chk(rq[2], 8'(c << SRC_CENT_LSB), "hour and century");
      chk(rq[3], 8'h01, "day of week");
      chk(rq[4], i2b(d), "date");
      chk(rq[5], i2b(m), "month");
      chk(rq[6], i2b(y), "year");
    end
    // Alarm compare of seconds (00 here) against the byte under an idle pointer
    for (int k = 0; k < 2; k++)
    begin
      pf_in = (k == 1);
      dq = '{8'(1 - k)};
      wr(SRC_A_USER0);
      set_ptr(SRC_A_USER0);
      host.stop();
      cyc_n(4);
      chk({7'h0, alarm}, {7'h0, mem_m[SRC_A_USER0] == 8'h00}, "alarm match");
    end
    pf_in = 1'b0;
    // A one-cycle request is shorter than the debounce time and must not reset
    req_a = 1'b0;
    cyc_n(1);
    req_a = 1'b1;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      cyc_n(1);
      r = r | {7'h0, rst_out};
    end
    chk(r, 8'h00, "request glitch");
    // Each reset request alone forces the reset output
    for (int k = 0; k < 2; k++)
    begin
      {req_a, req_b} = (k == 0) ? 2'b01 : 2'b10;
      cyc_n(14);
      chk({7'h0, rst_out}, 8'h01, "request reset");
      {req_a, req_b} = 2'b11;
      for (int i = 0; i < 60 && rst_out !== 1'b0; i++) cyc_n(1);
      chk({7'h0, rst_out}, 8'h00, "request reset end");
    end
    // Main power failure and return
    pf_in = 1'b1;
    cyc_n(10);
    chk({6'h0, on_batt, pf_flag}, 8'h03, "battery on");
    pf_in = 1'b0;
    cyc_n(10);
    chk({6'h0, on_batt, pf_flag}, 8'h00, "battery off");
    tally_and_finish();
  end
endmodule : serial_rtc_register_core_tb_top

// ==== tb/src_core_assertions.sv ====
/*
  Port checker for the register core: reset stretch, request
  debounce, supply switch-over and SDA drive timing.
  Assumes binding onto src_core on its single system clock.
*/
`timescale 1ns/1ps
module src_core_assertions #(
  parameter int DEB_CYCLES = 2
)(
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic scl_in,
  input  wire logic sda_oe_out,
  input  wire logic power_fail_sense_in,
  input  wire logic reset_request_in_a,
  input  wire logic reset_request_in_b,
  input  wire logic power_fail_flag_out,
  input  wire logic on_battery_out,
  input  wire logic reset_out,
  input  wire logic alarm_match_out
);
  // Slack covers the two-flop sync plus the output register
  localparam int LIM = DEB_CYCLES + 8;
  int low_a_reg;
  int low_b_reg;
  int low_a_next;
  int low_b_next;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // Saturating low-time counters so long requests never wrap
  always_comb
  begin
    low_a_next = reset_request_in_a ? 0 : ((low_a_reg < LIM) ? low_a_reg + 1 : LIM);
    low_b_next = reset_request_in_b ? 0 : ((low_b_reg < LIM) ? low_b_reg + 1 : LIM);
  end
  always_ff @(posedge clk_sys_in)
  begin
    low_a_reg <= reset_in ? 0 : low_a_next;
    low_b_reg <= reset_in ? 0 : low_b_next;
  end
  a_por_stretch: assert property ($fell(reset_in) |-> reset_out [*8])
    else $error("reset output dropped early after release");
  a_req_a_reset: assert property ((low_a_reg == LIM) |-> reset_out)
    else $error("first reset request not passed to reset output");
  a_req_b_reset: assert property ((low_b_reg == LIM) |-> reset_out)
    else $error("second reset request not passed to reset output");
  a_batt_switch: assert property (power_fail_sense_in [*6] |->
      on_battery_out && power_fail_flag_out)
    else $error("no switch to battery on power fail");
  a_batt_return: assert property (!power_fail_sense_in [*6] |->
      !on_battery_out && !power_fail_flag_out)
    else $error("battery kept after power returned");
  a_sda_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data line changed while clock high");
  a_sda_bit_hold: assert property ($rose(sda_oe_out) |=> sda_oe_out [*8])
    else $error("driven bit released too soon");
  a_alarm_idle: assert property (alarm_match_out |-> !sda_oe_out)
    else $error("alarm match while bus driven");
endmodule : src_core_assertions

bind src_core src_core_assertions #(.DEB_CYCLES(DEB_CYCLES)) chk (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .scl_in(scl_in), .sda_oe_out(sda_oe_out),
  .power_fail_sense_in(power_fail_sense_in), .reset_request_in_a(reset_request_in_a),
  .reset_request_in_b(reset_request_in_b), .power_fail_flag_out(power_fail_flag_out),
  .on_battery_out(on_battery_out), .reset_out(reset_out), .alarm_match_out(alarm_match_out));

// ==== tb/src_i2c_host.sv ====
/*
  Behavioural two-wire bus host: START, STOP and byte transfers.
  Assumes an open-drain data line with a pull-up resolved outside.
*/
`timescale 1ns/1ps
module src_i2c_host (
  input  wire logic clk_sys_in,
  input  wire logic sda_line_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // Idle bus: both lines released high
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Eight cycles a phase, twice what the sync path needs
  task automatic half();
    repeat (8) @(posedge clk_sys_in);
    #1;
  endtask : half
  task automatic start();
    sda_low_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_low_out = 1'b1;
    half();
    scl_out = 1'b0;
  endtask : start
  task automatic stop();
    sda_low_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_low_out = 1'b0;
    half();
  endtask : stop
  // Data set while clock low, sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    sda_low_out = !b;
    half();
    scl_out = 1'b1;
    half();
    r = sda_line_in;
    scl_out = 1'b0;
  endtask : bit_x
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ack_in, ack_out);
  endtask : xfer
endmodule : src_i2c_host
